// File: rtl/arc_pkg.sv
// Purpose: constants and carrier types of the alarm routing register bank
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   byte address is four times the index
package arc_pkg;

   // ==========================================================
   // register indices and address width
   localparam logic [7:0]  IDX_CFG_ONE    = 8'h45;
   localparam logic [7:0]  IDX_MASK_A     = 8'h48;
   localparam logic [7:0]  IDX_MASK_B     = 8'h49;
   localparam logic [7:0]  IDX_FORCE_A    = 8'h4c;
   localparam logic [7:0]  IDX_FORCE_B    = 8'h4d;
   localparam logic [7:0]  IDX_CTRL       = 8'h60;
   localparam logic [7:0]  IDX_STATE      = 8'h61;
   localparam logic [7:0]  IDX_LIVE_A     = 8'h62;
   localparam logic [7:0]  IDX_LIVE_B     = 8'h63;
   localparam logic [7:0]  IDX_IRQ_STAT   = 8'h64;
   localparam logic [7:0]  IDX_IRQ_MASK   = 8'h65;
   localparam int          ADDR_W         = 12;

   // ==========================================================
   // reset values and writable-bit masks
   localparam logic [15:0] RST_CFG_ONE    = 16'h1101;
   localparam logic [15:0] RST_MASK_A     = 16'h0000;
   localparam logic [15:0] RST_MASK_B     = 16'h1833;
   localparam logic [15:0] RST_FORCE      = 16'h0000;
   localparam logic [15:0] WR_CFG_ONE     = 16'h773f;
   localparam logic [15:0] BITS_A         = 16'h0133;
   localparam logic [15:0] BITS_B         = 16'h1833;
   localparam logic [15:0] BITS_FORCE_B   = 16'h3833;
   localparam logic [2:0]  BITS_IRQ       = 3'h7;

   // ==========================================================
   // field positions
   localparam int          POS_WIN_B      = 12;
   localparam int          POS_WIN_A      = 8;
   localparam int          POS_ROLE       = 0;
   localparam int          POS_NEG_B      = 5;
   localparam int          POS_NEG_A      = 4;
   localparam int          POS_ALM_IN     = 13;
   localparam int          POS_FORCE_EN   = 0;
   localparam int          POS_HOLD_DIS   = 1;

   // ==========================================================
   // window and role encodings
   localparam logic [2:0]  WIN_LOW        = 3'h1;
   localparam logic [2:0]  WIN_MID        = 3'h2;
   localparam logic [2:0]  WIN_HIGH       = 3'h4;
   localparam logic [5:0]  ROLE_RESET     = 6'h01;
   localparam logic [5:0]  ROLE_ALARM_OUT = 6'h02;
   localparam logic [5:0]  ROLE_GPIO      = 6'h04;
   localparam logic [5:0]  ROLE_DAC_LOAD  = 6'h08;
   localparam logic [5:0]  ROLE_ALARM_IN  = 6'h10;
   localparam logic [5:0]  ROLE_DRIVE_TWO = 6'h20;

   // window limits in millivolts, signed
   localparam logic signed [15:0] MV_FLOOR     = -16'sd11000;
   localparam logic signed [15:0] MV_TOP_LOW   = -16'sd3000;
   localparam logic signed [15:0] MV_TOP_MID   = -16'sd4500;
   localparam logic signed [15:0] MV_TOP_HIGH  = -16'sd7500;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic [15:0] grp_a;
      logic [15:0] grp_b;
   } arc_alarm_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
   } arc_access_t;

endpackage

// File: rtl/arc_ahb_front.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers only, one slave on the bus
// Notes:   writes apply at end of data phase
`timescale 1ns/1ps
module arc_ahb_front
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic                  hready,
   output      logic                  hreadyout,
   output      logic                  hresp,
   output      arc_pkg::arc_access_t  acc
);

   // ==========================================================
   // address phase qualification
   wire logic take;
   assign take = hsel & hready & htrans[1];

   // ==========================================================
   // capture address phase for the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         acc <= '0;
      else if (hready)
      begin
         acc.wr   <= take & hwrite;
         acc.rd   <= take & ~hwrite;
         acc.addr <= haddr[arc_pkg::ADDR_W-1:0];
      end
   end

   // never stalls and never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

endmodule

// File: rtl/arc_top.sv
// What this block does
// - group B negative window select flags alarm
// - group A negative window, same codes
// - one-hot field picks multi-function pin role
// - mask bit 8 routes temperature alarm
// - mask bit 5 routes second ADC input
// - mask bit 4 routes first ADC input
// - mask bit 1 routes second sense channel
// - mask bit 0 routes first sense channel
// - mask bit 12 routes reference alarm, default on
// - mask bit 11 routes thermal error, default on
// - mask bit 5 routes group B negative
// - mask bit 4 routes group A negative
// - mask bit 1 routes group B positive
// - mask bit 0 routes group A positive
// - force enable makes force bits the status
// - latched flag clears on read after subsiding
//
// Purpose: alarm routing and configuration registers over AHB-Lite
// Assumes: monitor codes and alarm levels come from logic on hclk
// Notes:   multi-function pin input is synchronised
`timescale 1ns/1ps
module arc_top
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output      logic                 hreadyout,
   output      logic                 hresp,
   output      logic [31:0]          hrdata,
   input  wire arc_pkg::arc_alarm_t  mon_alarm,
   input  wire logic signed [15:0]   neg_supply_mv_grp_a,
   input  wire logic signed [15:0]   neg_supply_mv_grp_b,
   input  wire logic                 mfp_in,
   output      logic                 mfp_out,
   output      logic                 mfp_oe,
   output      logic [5:0]           multi_pin_role_select,
   output      logic                 global_alarm_flag,
   output      logic                 irq
);

   // ==========================================================
   // bus front end
   arc_pkg::arc_access_t acc;

   arc_ahb_front u_front
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .acc       (acc)
   );

   // ==========================================================
   // address decode of the data phase
   wire logic [9:0]  word_idx;
   wire logic        idx_ok;
   wire logic        wr_cfg;
   wire logic        wr_mask_a;
   wire logic        wr_mask_b;
   wire logic        wr_force_a;
   wire logic        wr_force_b;
   wire logic        wr_ctrl;
   wire logic        wr_irq_stat;
   wire logic        wr_irq_mask;
   wire logic        rd_state;

   assign word_idx    = acc.addr[arc_pkg::ADDR_W-1:2];
   // indices above 8 bits are unmapped
   assign idx_ok      = (word_idx[9:8] == 2'h0);
   assign wr_cfg      = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_CFG_ONE);
   assign wr_mask_a   = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_MASK_A);
   assign wr_mask_b   = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_MASK_B);
   assign wr_force_a  = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_FORCE_A);
   assign wr_force_b  = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_FORCE_B);
   assign wr_ctrl     = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_CTRL);
   assign wr_irq_stat = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_IRQ_STAT);
   assign wr_irq_mask = acc.wr & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_IRQ_MASK);
   assign rd_state    = acc.rd & idx_ok
                        & (word_idx[7:0] == arc_pkg::IDX_STATE);

   // ==========================================================
   // software registers
   logic [15:0] cfg_one;
   logic [15:0] mask_a;
   logic [15:0] mask_b;
   logic [15:0] force_a;
   logic [15:0] force_b;
   logic [1:0]  ctrl;
   logic [2:0]  irq_mask;

   // reserved bits dropped on write, read zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_one  <= arc_pkg::RST_CFG_ONE;
         mask_a   <= arc_pkg::RST_MASK_A;
         mask_b   <= arc_pkg::RST_MASK_B;
         force_a  <= arc_pkg::RST_FORCE;
         force_b  <= arc_pkg::RST_FORCE;
         ctrl     <= 2'h0;
         irq_mask <= 3'h0;
      end
      else
      begin
         if (wr_cfg)
            cfg_one <= hwdata[15:0] & arc_pkg::WR_CFG_ONE;
         if (wr_mask_a)
            mask_a <= hwdata[15:0] & arc_pkg::BITS_A;
         if (wr_mask_b)
            mask_b <= hwdata[15:0] & arc_pkg::BITS_B;
         if (wr_force_a)
            force_a <= hwdata[15:0] & arc_pkg::BITS_A;
         if (wr_force_b)
            force_b <= hwdata[15:0] & arc_pkg::BITS_FORCE_B;
         if (wr_ctrl)
            ctrl <= hwdata[1:0];
         if (wr_irq_mask)
            irq_mask <= hwdata[2:0] & arc_pkg::BITS_IRQ;
      end
   end

   // ==========================================================
   // field extraction
   wire logic [2:0] win_a;
   wire logic [2:0] win_b;
   wire logic       force_en;
   wire logic       hold_dis;

   assign win_b    = cfg_one[arc_pkg::POS_WIN_B +: 3];
   assign win_a    = cfg_one[arc_pkg::POS_WIN_A +: 3];
   assign multi_pin_role_select = cfg_one[arc_pkg::POS_ROLE +: 6];
   assign force_en = ctrl[arc_pkg::POS_FORCE_EN];
   assign hold_dis = ctrl[arc_pkg::POS_HOLD_DIS];

   // ==========================================================
   // role decode of the multi-function pin
   wire logic role_alarm_out;
   wire logic role_alarm_in;

   // exact compare: two-bit codes pick no role
   assign role_alarm_out = (multi_pin_role_select
                            == arc_pkg::ROLE_ALARM_OUT);
   assign role_alarm_in  = (multi_pin_role_select
                            == arc_pkg::ROLE_ALARM_IN);

   // ==========================================================
   // pin input synchroniser, first stage read only by second
   logic pin_meta;
   logic pin_sync;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end
      else
      begin
         pin_meta <= mfp_in;
         pin_sync <= pin_meta;
      end
   end

   // ==========================================================
   // negative supply window checks
   function automatic logic outside_window
   (
      input logic [2:0]         sel,
      input logic signed [15:0] mv
   );
      logic signed [15:0] top;
      logic               bad_sel;
      top     = arc_pkg::MV_TOP_LOW;
      bad_sel = 1'b0;
      case (sel)
         arc_pkg::WIN_LOW:  top = arc_pkg::MV_TOP_LOW;
         arc_pkg::WIN_MID:  top = arc_pkg::MV_TOP_MID;
         arc_pkg::WIN_HIGH: top = arc_pkg::MV_TOP_HIGH;
         default:           bad_sel = 1'b1;
      endcase
      // invalid window code alarms
      return bad_sel | (mv < arc_pkg::MV_FLOOR) | (mv > top);
   endfunction

   wire logic neg_supply_alarm_grp_a;
   wire logic neg_supply_alarm_grp_b;

   assign neg_supply_alarm_grp_b =
      outside_window(win_b, neg_supply_mv_grp_b);
   assign neg_supply_alarm_grp_a =
      outside_window(win_a, neg_supply_mv_grp_a);

   // ==========================================================
   // alarm status assembly, monitored or forced
   logic [15:0] cond_b;
   wire logic [15:0] stat_a;
   wire logic [15:0] stat_b;

   always_comb
   begin
      cond_b = mon_alarm.grp_b & arc_pkg::BITS_B;
      cond_b[arc_pkg::POS_NEG_B]  = neg_supply_alarm_grp_b;
      cond_b[arc_pkg::POS_NEG_A]  = neg_supply_alarm_grp_a;
      cond_b[arc_pkg::POS_ALM_IN] = role_alarm_in & pin_sync;
   end

   // force bits win over the monitored level
   assign stat_a = force_en ? force_a
                            : (mon_alarm.grp_a & arc_pkg::BITS_A);
   assign stat_b = force_en ? force_b : cond_b;

   // ==========================================================
   // routing to the alarm output through the source masks
   wire logic [15:0] routed_a;
   wire logic [15:0] routed_b;
   wire logic        routed_any;

   // per-bit gating; mask_a bits 8,5,4,1,0
   assign routed_a = stat_a & mask_a;
   // mask_b bits 12,11,5,4,1,0
   assign routed_b = stat_b & mask_b;
   assign routed_any = (|routed_a) | (|routed_b);

   // ==========================================================
   // global flag latch, cleared by a read once the cause is gone
   logic  flag_latch;
   wire logic read_clear;

   // a live cause re-sets the latch
   assign read_clear = rd_state & ~routed_any;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_latch <= 1'b0;
      else
         flag_latch <= routed_any | (flag_latch & ~read_clear);
   end

   // holding off: flag follows the cause
   assign global_alarm_flag = hold_dis ? routed_any : flag_latch;

   // ==========================================================
   // pin drive, registered so the pin never glitches
   logic pin_level;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_level <= 1'b0;
         mfp_oe    <= 1'b0;
      end
      else
      begin
         pin_level <= role_alarm_out & global_alarm_flag;
         mfp_oe    <= role_alarm_out;
      end
   end

   assign mfp_out = pin_level;

   // ==========================================================
   // irq events: new alarm per group, flag rise
   logic [15:0] prev_a;
   logic [15:0] prev_b;
   logic        prev_flag;
   logic [2:0]  irq_stat;
   wire logic [2:0] irq_set;
   wire logic [2:0] irq_clr;

   assign irq_set = {global_alarm_flag & ~prev_flag,
                     |(stat_b & ~prev_b),
                     |(stat_a & ~prev_a)};
   assign irq_clr = wr_irq_stat ? hwdata[2:0] : 3'h0;

   // set wins over a same-cycle write-one clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev_a    <= 16'h0000;
         prev_b    <= 16'h0000;
         prev_flag <= 1'b0;
         irq_stat  <= 3'h0;
      end
      else
      begin
         prev_a    <= stat_a;
         prev_b    <= stat_b;
         prev_flag <= global_alarm_flag;
         irq_stat  <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ==========================================================
   // data phase read mux, unmapped reads zero
   logic [15:0] rd_word;

   always_comb
   begin
      rd_word = 16'h0000;
      if (acc.rd & idx_ok)
      begin
         case (word_idx[7:0])
            arc_pkg::IDX_CFG_ONE:  rd_word = cfg_one;
            arc_pkg::IDX_MASK_A:   rd_word = mask_a;
            arc_pkg::IDX_MASK_B:   rd_word = mask_b;
            arc_pkg::IDX_FORCE_A:  rd_word = force_a;
            arc_pkg::IDX_FORCE_B:  rd_word = force_b;
            arc_pkg::IDX_CTRL:     rd_word = {14'h0000, ctrl};
            arc_pkg::IDX_STATE:    rd_word = {14'h0000, pin_level,
                                              global_alarm_flag};
            arc_pkg::IDX_LIVE_A:   rd_word = stat_a;
            arc_pkg::IDX_LIVE_B:   rd_word = stat_b;
            arc_pkg::IDX_IRQ_STAT: rd_word = {13'h0000, irq_stat};
            arc_pkg::IDX_IRQ_MASK: rd_word = {13'h0000, irq_mask};
            default:               rd_word = 16'h0000;
         endcase
      end
   end

   // upper half zero; only word transfers
   assign hrdata = {16'h0000, rd_word};

endmodule

// File: tb/arc_top_asserts.sv
// Purpose: port checks of the alarm bank
// Assumes: registers change only by bus writes
// Notes:   shadows follow the bus writes
`timescale 1ns/1ps
module arc_top_asserts
(
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [31:0]         hwdata,
   input wire logic                hready,
   input wire arc_pkg::arc_alarm_t mon_alarm,
   input wire logic signed [15:0]  neg_supply_mv_grp_a,
   input wire logic signed [15:0]  neg_supply_mv_grp_b,
   input wire logic                mfp_out,
   input wire logic                mfp_oe,
   input wire logic [5:0]          multi_pin_role_select,
   input wire logic                global_alarm_flag
);
   // ==========================================================
   // register shadows
   logic        dp_wr;
   logic        dp_rd;
   logic [9:0]  dp_idx;
   logic [15:0] s_cfg;
   logic [15:0] s_ma;
   logic [15:0] s_mb;
   logic [1:0]  s_ctl;
   wire         take = hsel && hready && htrans[1];

   // data phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr  <= 1'b0;
         dp_rd  <= 1'b0;
         dp_idx <= 10'h0;
      end
      else if (hready)
      begin
         dp_wr  <= take && hwrite;
         dp_rd  <= take && !hwrite;
         dp_idx <= haddr[11:2];
      end
   end

   // writes land at end of data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_cfg <= 16'h1101;
         s_ma  <= 16'h0000;
         s_mb  <= 16'h1833;
         s_ctl <= 2'h0;
      end
      else if (dp_wr)
      begin
         if (dp_idx == 10'h045)
            s_cfg <= hwdata[15:0] & 16'h773f;
         if (dp_idx == 10'h048)
            s_ma <= hwdata[15:0] & 16'h0133;
         if (dp_idx == 10'h049)
            s_mb <= hwdata[15:0] & 16'h1833;
         if (dp_idx == 10'h060)
            s_ctl <= hwdata[1:0];
      end
   end

   // unlisted window codes alarm
   function automatic logic out_win(input logic [2:0]         w,
                                    input logic signed [15:0] mv);
      logic signed [15:0] top;
      top = (w == 3'h1) ? -16'sd3000 :
            (w == 3'h2) ? -16'sd4500 : -16'sd7500;
      return !(w inside {3'h1, 3'h2, 3'h4}) ||
             mv < -16'sd11000 || mv > top;
   endfunction

   // ==========================================================
   // expected alarm path
   wire        out_a   = out_win(s_cfg[10:8], neg_supply_mv_grp_a);
   wire        out_b   = out_win(s_cfg[14:12], neg_supply_mv_grp_b);
   wire [15:0] st_b    = {mon_alarm.grp_b[15:6], out_b, out_a,
                          mon_alarm.grp_b[3:0]};
   wire        routed  = |(mon_alarm.grp_a & s_ma) | |(st_b & s_mb);
   wire        direct  = s_ctl[1] && !s_ctl[0];
   wire        st_rd   = dp_rd && dp_idx == 10'h061;
   wire        alm_on  = multi_pin_role_select == 6'h02;
   wire        pin_due = alm_on && global_alarm_flag;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_role_write: assert property (
      dp_wr && dp_idx == 10'h045 |=>
      multi_pin_role_select == $past(hwdata[5:0]))
      else $error("role mismatch");
   a_oe_role: assert property (
      1'b1 |=> mfp_oe == $past(alm_on))
      else $error("oe mismatch");
   a_pin_level: assert property (
      1'b1 |=> mfp_out == $past(pin_due))
      else $error("pin mismatch");
   a_win_b: assert property (
      direct && s_mb[5] && out_b |-> global_alarm_flag)
      else $error("grp b alarm lost");
   a_win_a: assert property (
      direct && s_mb[4] && out_a |-> global_alarm_flag)
      else $error("grp a alarm lost");
   a_flag_raise: assert property (
      direct && routed |-> global_alarm_flag)
      else $error("flag low");
   a_flag_quiet: assert property (
      direct && !routed |-> !global_alarm_flag)
      else $error("flag high");
   a_hold_latch: assert property (
      !s_ctl[1] && global_alarm_flag && !st_rd ##1 !s_ctl[1]
      |-> global_alarm_flag)
      else $error("latch dropped");
endmodule

bind arc_top arc_top_asserts i_arc_top_asserts
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .mon_alarm(mon_alarm),
   .neg_supply_mv_grp_a(neg_supply_mv_grp_a),
   .neg_supply_mv_grp_b(neg_supply_mv_grp_b),
   .mfp_out(mfp_out), .mfp_oe(mfp_oe),
   .multi_pin_role_select(multi_pin_role_select),
   .global_alarm_flag(global_alarm_flag)
);

// File: tb/arc_host_mon.sv
// Purpose: host controller watching the alarm output pin
// Assumes: bench resolves the pin level
// Notes:   counts alarm assertions
`timescale 1ns/1ps
module arc_host_mon
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin_level,
   output      int   alarm_count
);
   logic last;

   // ==========================================================
   // rising-edge counter
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         last        <= 1'b0;
         alarm_count <= 0;
      end
      else
      begin
         last <= pin_level;
         if (pin_level && !last)
            alarm_count <= alarm_count + 1;
      end
   end
endmodule

// File: tb/test_alarm_routing_config.sv
// Purpose: self-checking bench of the alarm bank
// Assumes: one clock, idle pin pulled low
// Notes:   inputs change by NBA at rising edges
`timescale 1ns/1ps
module test_alarm_routing_config;
   logic                hclk    = 1'b0;
   logic                hresetn = 1'b0;
   logic                hsel    = 1'b0;
   logic [31:0]         haddr   = 32'h0;
   logic [1:0]          htrans  = 2'h0;
   logic                hwrite  = 1'b0;
   logic [31:0]         hwdata  = 32'h0;
   arc_pkg::arc_alarm_t mon     = '0;
   logic signed [15:0]  mva     = -16'sd10000;
   logic signed [15:0]  mvb     = -16'sd10000;
   logic                hreadyout, mfp_out, mfp_oe, flag, irq;
   logic [31:0]         hrdata, rd;
   logic [5:0]          role;
   int                  miscompares = 0, comparisons = 0, hcnt;
   // pull-down while undriven
   wire                 pin = mfp_oe ? mfp_out : 1'b0;

   always #2 hclk = ~hclk;

   arc_top i_arc_top
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(), .hrdata(hrdata), .mon_alarm(mon),
      .neg_supply_mv_grp_a(mva), .neg_supply_mv_grp_b(mvb),
      .mfp_in(pin), .mfp_out(mfp_out), .mfp_oe(mfp_oe),
      .multi_pin_role_select(role), .global_alarm_flag(flag),
      .irq(irq)
   );

   arc_host_mon i_arc_host_mon
   (
      .hclk(hclk), .hresetn(hresetn), .pin_level(pin),
      .alarm_count(hcnt)
   );

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single transfer, waits on hready
   task automatic bus(input logic w, input logic [7:0] ix,
                      input logic [15:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {22'h0, ix, 2'b00};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] ix, input logic [15:0] d);
      bus(1'b1, ix, d);
   endtask

   task automatic rdc(input logic [7:0] ix, input logic [31:0] ex);
      bus(1'b0, ix, 16'h0);
      chk(rd, ex);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rdc(8'h45, 32'h1101);
      rdc(8'h48, 32'h0);
      rdc(8'h49, 32'h1833);
      rdc(8'h4c, 32'h0);
      chk(role, 32'h1);
      wr(8'h40, 16'hffff);
      rdc(8'h40, 32'h0);
   endtask

   // reserved bits read zero
   task automatic t_access;
      logic [7:0]  ix [4] = '{8'h45, 8'h48, 8'h49, 8'h4c};
      logic [15:0] ex [4] = '{16'h773f, 16'h0133, 16'h1833, 16'h0133};
      for (int i = 0; i < 4; i++)
      begin
         wr(ix[i], 16'hffff);
         rdc(ix[i], {16'h0, ex[i]});
         wr(ix[i], 16'h0000);
         rdc(ix[i], 32'h0);
      end
   endtask

   // each monitor source alone, masked, then unmasked, then masked again
   task automatic t_mask;
      int         sh [9] = '{24, 21, 20, 17, 16, 12, 11, 1, 0};
      logic [7:0] mi;
      wr(8'h60, 16'h0002);
      for (int i = 0; i < 9; i++)
      begin
         mi = (i < 5) ? 8'h48 : 8'h49;
         @(posedge hclk);
         mon <= arc_pkg::arc_alarm_t'(32'h1 << sh[i]);
         settle(1);
         chk(flag, 32'h0);
         wr(mi, 16'h1 << (sh[i] % 16));
         settle(1);
         chk(flag, 32'h1);
         wr(mi, 16'h0000);
         settle(1);
         chk(flag, 32'h0);
      end
      @(posedge hclk);
      mon <= '0;
   endtask

   // window edges inside, 1 mV beyond out
   task automatic t_window;
      int top [3] = '{-3000, -4500, -7500};
      int v;
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h45, {1'b0, 3'h1 << c, 1'b0, 3'h1 << c, 8'h02});
         for (int k = 0; k < 8; k++)
         begin
            v = (k % 4 == 0) ? top[c] : (k % 4 == 1) ? top[c] + 1 :
                (k % 4 == 2) ? -11000 : -11001;
            wr(8'h49, (k < 4) ? 16'h0020 : 16'h0010);
            mvb <= (k < 4) ? 16'(v) : -16'sd10000;
            mva <= (k < 4) ? -16'sd10000 : 16'(v);
            settle(1);
            chk(flag, 32'(k % 2));
         end
      end
   endtask

   // force overrides monitor both ways
   task automatic t_force;
      wr(8'h48, 16'h0100);
      mva <= -16'sd10000;
      wr(8'h4c, 16'h0100);
      wr(8'h60, 16'h0003);
      settle(1);
      chk(flag, 32'h1);
      wr(8'h4c, 16'h0000);
      mon <= arc_pkg::arc_alarm_t'(32'h0100_0000);
      settle(1);
      chk(flag, 32'h0);
      wr(8'h60, 16'h0002);
      settle(1);
      chk(flag, 32'h1);
      wr(8'h48, 16'h0001);
      mon <= '0;
   endtask

   // held flag, read clear, irq
   task automatic t_latch;
      int h0;
      wr(8'h60, 16'h0000);
      bus(1'b0, 8'h61, 16'h0);
      settle(2);
      wr(8'h64, 16'h0007);
      wr(8'h65, 16'h0000);
      h0 = hcnt;
      mon <= arc_pkg::arc_alarm_t'(32'h0001_0000);
      settle(3);
      rdc(8'h61, 32'h3);
      mon <= '0;
      settle(2);
      chk(flag, 32'h1);
      chk(pin, 32'h1);
      chk(irq, 32'h0);
      rdc(8'h64, 32'h5);
      wr(8'h65, 16'h0004);
      settle(1);
      chk(irq, 32'h1);
      wr(8'h64, 16'h0004);
      settle(1);
      chk(irq, 32'h0);
      rdc(8'h64, 32'h1);
      rdc(8'h61, 32'h3);
      rdc(8'h61, 32'h0);
      chk(flag, 32'h0);
      chk(hcnt, h0 + 1);
   endtask

   // only the alarm role drives the pin
   task automatic t_roles;
      logic [5:0] r;
      wr(8'h60, 16'h0002);
      mon <= arc_pkg::arc_alarm_t'(32'h0001_0000);
      for (int i = 0; i < 6; i++)
      begin
         r = 6'h1 << i;
         wr(8'h45, {10'h044, r});
         settle(2);
         chk(role, {26'h0, r});
         chk(mfp_oe, 32'(i == 1));
         chk(pin, 32'(i == 1));
      end
   endtask

   task automatic final_report;
      $display("comparisons=%0d miscompares=%0d", comparisons,
               miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_access;
      t_mask;
      t_window;
      t_force;
      t_latch;
      t_roles;
      final_report;
   end

   // watchdog, run needs a few hundred cycles
   initial
   begin
      #80000;
      miscompares++;
      final_report;
   end
endmodule
